// *** core/clkctl_pkg.sv ***
// Shared constants, types and state records for the system clock control block.
// Assumes an 8-bit special-function register port and a 100 MHz sampling clock.
package clkctl_pkg;

	// Register addresses on the special-function register port.
	localparam logic [7:0] ADDR_INT_CTRL = 8'h8a;
	localparam logic [7:0] ADDR_INT_TRIM = 8'h8b;
	localparam logic [7:0] ADDR_EXT_CTRL = 8'h8c;
	localparam logic [7:0] ADDR_SRC_SEL = 8'h97;

	// Field positions.
	localparam int INT_EN_BIT = 7;
	localparam int INT_RDY_BIT = 6;
	localparam int INT_DIV_LSB = 0;
	localparam int OUT_DIV_LSB = 4;
	localparam int SRC_CODE_LSB = 0;
	localparam int XTAL_VALID_BIT = 7;
	localparam int EXT_MODE_LSB = 4;
	localparam int EXT_FREQ_LSB = 0;

	// Reset values.
	localparam logic [7:0] INT_CTRL_RESET = 8'hc0;
	localparam logic [7:0] EXT_CTRL_RESET = 8'h00;
	localparam logic [7:0] SRC_SEL_RESET = 8'h00;
	// Arbitrary neutral trim value; the real part carries a factory constant.
	localparam logic [7:0] TRIM_DEFAULT = 8'h80;
	localparam logic [7:0] RDATA_IDLE = 8'h00;

	// System clock source codes.
	typedef enum logic [1:0] {
		SRC_INTERNAL = 2'h0,
		SRC_EXTERNAL = 2'h1,
		SRC_PLL = 2'h2,
		SRC_RESERVED = 2'h3
	} src_code_e;

	// External oscillator mode codes and mode groups (upper two mode bits).
	localparam logic [2:0] EXT_MODE_CMOS = 3'h2;
	localparam logic [2:0] EXT_MODE_CMOS_DIV2 = 3'h3;
	localparam logic [2:0] EXT_MODE_XTAL = 3'h6;
	localparam logic [2:0] EXT_MODE_XTAL_DIV2 = 3'h7;
	localparam logic [1:0] EXT_GRP_OFF = 2'h0;
	localparam logic [1:0] EXT_GRP_RC = 2'h2;
	localparam logic [1:0] EXT_GRP_XTAL = 2'h3;

	// Divider shifts: shift n divides by two to the n.
	localparam logic [1:0] DIV_SHIFT_MAX = 2'h3;
	localparam logic [1:0] DIV_SHIFT_NONE = 2'h0;
	localparam logic [1:0] DIV_SHIFT_HALF = 2'h1;
	localparam int DIV_CNT_W = 3;

	// Timing.
	localparam int CLK_FREQ_MHZ = 100;
	localparam int MCD_TIMEOUT_MIN_US = 100;
	localparam int MCD_TIMEOUT_US = 220;
	localparam int MCD_TIMEOUT_MAX_US = 500;
	localparam int MCD_TIMEOUT_CYCLES = MCD_TIMEOUT_US * CLK_FREQ_MHZ;
	localparam int MCD_CNT_W = 16;

	// Register port request.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} sfr_req_s;

	typedef struct packed {
		logic prev;
		logic [DIV_CNT_W-1:0] cnt;
		logic out;
	} div_state_s;

	typedef enum logic [2:0] {
		SW_RUN = 3'b001,
		SW_OLD_LOW = 3'b010,
		SW_NEW_LOW = 3'b100
	} sw_state_e;

	typedef struct packed {
		sw_state_e st;
		logic [1:0] cur;
		logic [1:0] tgt;
		logic out;
	} sw_state_s;

	typedef struct packed {
		logic int_en;
		logic [1:0] int_div;
		logic [7:0] trim;
		logic [1:0] out_div;
		logic [1:0] src;
		logic [2:0] ext_mode;
		logic [2:0] ext_freq;
		logic int_ready;
		logic xtal_valid;
		logic pll_lock;
		logic [7:0] rdata;
		logic prev_sys;
		logic [MCD_CNT_W-1:0] mcd_cnt;
		logic mcd_reset;
	} top_state_s;

endpackage

// *** core/clk_div.sv ***
// Power-of-two divider for a sampled clock level.
// Assumes the input level changes slower than half the sampling clock rate.
`timescale 1ns/100ps
module clk_div (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic clk_in,
	input wire logic [1:0] shift,
	output logic clk_out
);
	clkctl_pkg::div_state_s s_ff;
	clkctl_pkg::div_state_s nxt_s;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.prev = clk_in;
		if (clk_in && !s_ff.prev) begin
			nxt_s.cnt = clkctl_pkg::DIV_CNT_W'(s_ff.cnt + 1'b1);
		end
		// Counter bit n-1 toggles every 2^(n-1) rising edges, giving division by 2^n.
		if (shift == clkctl_pkg::DIV_SHIFT_NONE) begin
			nxt_s.out = clk_in;
		end else begin
			nxt_s.out = nxt_s.cnt[2'(shift - 2'h1)];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= '0;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	assign clk_out = s_ff.out;
endmodule

// *** core/clk_switch.sv ***
// Runt-free selector among three sampled clock levels.
// Assumes each selected source is running; a stopped target holds the output low.
`timescale 1ns/100ps
module clk_switch (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [2:0] src_levels,
	input wire logic [1:0] sel,
	output logic sw_out
);
	clkctl_pkg::sw_state_s s_ff;
	clkctl_pkg::sw_state_s nxt_s;

	function automatic logic pick(input logic [2:0] lv, input logic [1:0] code);
		logic r;
		r = 1'b0;
		if (code == clkctl_pkg::SRC_INTERNAL) begin
			r = lv[0];
		end else if (code == clkctl_pkg::SRC_EXTERNAL) begin
			r = lv[1];
		end else if (code == clkctl_pkg::SRC_PLL) begin
			r = lv[2];
		end
		return r;
	endfunction

	always_comb begin
		nxt_s = s_ff;
		case (s_ff.st)
			clkctl_pkg::SW_RUN: begin
				nxt_s.out = pick(src_levels, s_ff.cur);
				// The reserved code leaves the running source in place.
				if (sel != s_ff.cur && sel != clkctl_pkg::SRC_RESERVED) begin
					nxt_s.tgt = sel;
					nxt_s.st = clkctl_pkg::SW_OLD_LOW;
				end
			end
			clkctl_pkg::SW_OLD_LOW: begin
				// Release the old source only in its low phase.
				if (!pick(src_levels, s_ff.cur)) begin
					nxt_s.out = 1'b0;
					nxt_s.st = clkctl_pkg::SW_NEW_LOW;
				end else begin
					nxt_s.out = 1'b1;
				end
			end
			clkctl_pkg::SW_NEW_LOW: begin
				// Join the new source only in its low phase, so no runt pulse appears.
				nxt_s.out = 1'b0;
				if (!pick(src_levels, s_ff.tgt)) begin
					nxt_s.cur = s_ff.tgt;
					nxt_s.st = clkctl_pkg::SW_RUN;
				end
			end
			default: begin
				nxt_s.st = clkctl_pkg::SW_RUN;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= '{st: clkctl_pkg::SW_RUN, cur: clkctl_pkg::SRC_INTERNAL,
				tgt: clkctl_pkg::SRC_INTERNAL, out: 1'b0};
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	assign sw_out = s_ff.out;
endmodule

// *** core/system_clock_control.sv ***
// System clock control: oscillator registers, source selection, output divider and
// missing clock detector. Assumes oscillator levels arrive synchronous to CLK and are
// slower than half its rate; registers sit on an 8-bit special-function register port.
`timescale 1ns/100ps
module system_clock_control #(
	parameter logic [7:0] TRIM_RESET = clkctl_pkg::TRIM_DEFAULT,
	parameter logic [15:0] MCD_TIMEOUT = 16'(clkctl_pkg::MCD_TIMEOUT_CYCLES)
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire clkctl_pkg::sfr_req_s SFR_REQ,
	output logic [7:0] SFR_RDATA,
	input wire logic INT_OSC_LEVEL,
	input wire logic INT_OSC_SETTLED,
	input wire logic CRYSTAL_PIN_A,
	input wire logic EXT_OSC_LEVEL,
	input wire logic CRYSTAL_STABLE,
	input wire logic PLL_CLOCK_LEVEL,
	input wire logic PLL_LOCKED,
	input wire logic MCD_ENABLE,
	output logic INT_OSC_ENABLE,
	output logic [7:0] INT_OSC_TRIM,
	output logic [2:0] EXT_OSC_MODE,
	output logic [2:0] EXT_FREQ_RANGE,
	output logic SYSTEM_CLOCK,
	output logic CLOCK_OUT,
	output logic EXT_PERIPH_CLOCK,
	output logic PLL_LOCK_FLAG,
	output logic MCD_RESET
);
	clkctl_pkg::top_state_s s_ff;
	clkctl_pkg::top_state_s nxt_s;

	logic int_level_gated;
	logic [1:0] int_shift;
	logic int_divided;
	logic ext_raw;
	logic [1:0] ext_shift;
	logic ext_divided;
	logic [1:0] ext_group;
	logic sys_level;

	// Internal oscillator path, gated by its enable and divided by 8, 4, 2 or 1.
	assign int_level_gated = INT_OSC_LEVEL & s_ff.int_en;
	assign int_shift = 2'(clkctl_pkg::DIV_SHIFT_MAX - s_ff.int_div);

	clk_div u_int_div (
		.clk(CLK),
		.rst_n(RST_N),
		.ce(CE),
		.clk_in(int_level_gated),
		.shift(int_shift),
		.clk_out(int_divided)
	);

	// External oscillator path: the mode picks the pin and whether a halving stage follows.
	assign ext_group = s_ff.ext_mode[2:1];

	always_comb begin
		ext_raw = 1'b0;
		ext_shift = clkctl_pkg::DIV_SHIFT_HALF;
		if (s_ff.ext_mode == clkctl_pkg::EXT_MODE_CMOS) begin
			ext_raw = CRYSTAL_PIN_A;
			ext_shift = clkctl_pkg::DIV_SHIFT_NONE;
		end else if (s_ff.ext_mode == clkctl_pkg::EXT_MODE_CMOS_DIV2) begin
			ext_raw = CRYSTAL_PIN_A;
		end else if (ext_group == clkctl_pkg::EXT_GRP_RC) begin
			ext_raw = EXT_OSC_LEVEL;
		end else if (s_ff.ext_mode == clkctl_pkg::EXT_MODE_XTAL) begin
			ext_raw = EXT_OSC_LEVEL;
			ext_shift = clkctl_pkg::DIV_SHIFT_NONE;
		end else if (s_ff.ext_mode == clkctl_pkg::EXT_MODE_XTAL_DIV2) begin
			ext_raw = EXT_OSC_LEVEL;
		end
	end

	clk_div u_ext_div (
		.clk(CLK),
		.rst_n(RST_N),
		.ce(CE),
		.clk_in(ext_raw),
		.shift(ext_shift),
		.clk_out(ext_divided)
	);

	// The selector assumes software only moves to a source that already runs.
	clk_switch u_switch (
		.clk(CLK),
		.rst_n(RST_N),
		.ce(CE),
		.src_levels({PLL_CLOCK_LEVEL, ext_divided, int_divided}),
		.sel(s_ff.src),
		.sw_out(sys_level)
	);

	clk_div u_out_div (
		.clk(CLK),
		.rst_n(RST_N),
		.ce(CE),
		.clk_in(sys_level),
		.shift(s_ff.out_div),
		.clk_out(CLOCK_OUT)
	);

	always_comb begin
		nxt_s = s_ff;

		// Status flags track the analog indications every cycle.
		nxt_s.int_ready = s_ff.int_en & INT_OSC_SETTLED;
		nxt_s.xtal_valid = (ext_group == clkctl_pkg::EXT_GRP_XTAL) & CRYSTAL_STABLE;
		nxt_s.pll_lock = PLL_LOCKED;

		// Register writes; read-only and reserved bits are not stored.
		if (SFR_REQ.we) begin
			if (SFR_REQ.addr == clkctl_pkg::ADDR_INT_CTRL) begin
				// Enable and divider land together, so one write can start and pick it.
				nxt_s.int_en = SFR_REQ.wdata[clkctl_pkg::INT_EN_BIT];
				nxt_s.int_div = SFR_REQ.wdata[clkctl_pkg::INT_DIV_LSB +: 2];
			end else if (SFR_REQ.addr == clkctl_pkg::ADDR_INT_TRIM) begin
				nxt_s.trim = SFR_REQ.wdata;
			end else if (SFR_REQ.addr == clkctl_pkg::ADDR_EXT_CTRL) begin
				nxt_s.ext_mode = SFR_REQ.wdata[clkctl_pkg::EXT_MODE_LSB +: 3];
				nxt_s.ext_freq = SFR_REQ.wdata[clkctl_pkg::EXT_FREQ_LSB +: 3];
			end else if (SFR_REQ.addr == clkctl_pkg::ADDR_SRC_SEL) begin
				nxt_s.out_div = SFR_REQ.wdata[clkctl_pkg::OUT_DIV_LSB +: 2];
				nxt_s.src = SFR_REQ.wdata[clkctl_pkg::SRC_CODE_LSB +: 2];
			end
		end

		// Register reads; the answer is registered and unmapped addresses read zero.
		if (SFR_REQ.re) begin
			nxt_s.rdata = clkctl_pkg::RDATA_IDLE;
			if (SFR_REQ.addr == clkctl_pkg::ADDR_INT_CTRL) begin
				nxt_s.rdata[clkctl_pkg::INT_EN_BIT] = s_ff.int_en;
				nxt_s.rdata[clkctl_pkg::INT_RDY_BIT] = s_ff.int_ready;
				nxt_s.rdata[clkctl_pkg::INT_DIV_LSB +: 2] = s_ff.int_div;
			end else if (SFR_REQ.addr == clkctl_pkg::ADDR_INT_TRIM) begin
				nxt_s.rdata = s_ff.trim;
			end else if (SFR_REQ.addr == clkctl_pkg::ADDR_EXT_CTRL) begin
				// Bit three is never stored and so always reads zero.
				nxt_s.rdata[clkctl_pkg::XTAL_VALID_BIT] = s_ff.xtal_valid;
				nxt_s.rdata[clkctl_pkg::EXT_MODE_LSB +: 3] = s_ff.ext_mode;
				nxt_s.rdata[clkctl_pkg::EXT_FREQ_LSB +: 3] = s_ff.ext_freq;
			end else if (SFR_REQ.addr == clkctl_pkg::ADDR_SRC_SEL) begin
				nxt_s.rdata[clkctl_pkg::OUT_DIV_LSB +: 2] = s_ff.out_div;
				nxt_s.rdata[clkctl_pkg::SRC_CODE_LSB +: 2] = s_ff.src;
			end
		end

		// Missing clock detector: any system clock edge restarts the count.
		nxt_s.prev_sys = sys_level;
		if (!MCD_ENABLE || (sys_level != s_ff.prev_sys)) begin
			nxt_s.mcd_cnt = '0;
			nxt_s.mcd_reset = 1'b0;
		end else if (s_ff.mcd_cnt >= 16'(MCD_TIMEOUT - 16'h0001)) begin
			nxt_s.mcd_reset = 1'b1;
		end else begin
			nxt_s.mcd_cnt = 16'(s_ff.mcd_cnt + 16'h0001);
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			s_ff <= '0;
			s_ff.int_en <= clkctl_pkg::INT_CTRL_RESET[clkctl_pkg::INT_EN_BIT];
			s_ff.int_div <= clkctl_pkg::INT_CTRL_RESET[clkctl_pkg::INT_DIV_LSB +: 2];
			s_ff.trim <= TRIM_RESET;
			s_ff.src <= clkctl_pkg::SRC_SEL_RESET[clkctl_pkg::SRC_CODE_LSB +: 2];
			s_ff.out_div <= clkctl_pkg::SRC_SEL_RESET[clkctl_pkg::OUT_DIV_LSB +: 2];
			s_ff.ext_mode <= clkctl_pkg::EXT_CTRL_RESET[clkctl_pkg::EXT_MODE_LSB +: 3];
			s_ff.ext_freq <= clkctl_pkg::EXT_CTRL_RESET[clkctl_pkg::EXT_FREQ_LSB +: 3];
		end else if (CE) begin
			s_ff <= nxt_s;
		end
	end

	assign SFR_RDATA = s_ff.rdata;
	assign INT_OSC_ENABLE = s_ff.int_en;
	assign INT_OSC_TRIM = s_ff.trim;
	assign EXT_OSC_MODE = s_ff.ext_mode;
	assign EXT_FREQ_RANGE = s_ff.ext_freq;
	assign SYSTEM_CLOCK = sys_level;
	assign EXT_PERIPH_CLOCK = ext_divided;
	assign PLL_LOCK_FLAG = s_ff.pll_lock;
	assign MCD_RESET = s_ff.mcd_reset;
endmodule

// *** tb/osc_model.sv ***
// Behavioural oscillators, crystal, CMOS clock and PLL beside the clock control block.
// Assumes one sampling clock; stop freezes every source at its present level.
`timescale 1ns/100ps
module osc_model (
	input wire logic clk,
	input wire logic int_en,
	input wire logic [2:0] ext_mode,
	input wire logic stop,
	output logic int_level,
	output logic int_settled,
	output logic pin_a,
	output logic ext_level,
	output logic xtal_stable,
	output logic pll_level,
	output logic pll_locked
);
	int cnt = 0;
	int xt = 0;
	always @(posedge clk) begin
		if (!stop) begin
			cnt <= cnt + 1;
		end
		xt <= (ext_mode[2:1] != 2'h0) ? xt + 1 : 0;
		int_settled <= int_en;
	end
	// The internal oscillator only runs while enabled.
	assign int_level = int_en && (cnt % 8 >= 4);
	assign pin_a = cnt % 10 >= 5;
	// The circuit output stays flat while the external circuit is off.
	assign ext_level = (ext_mode[2:1] != 2'h0) && (cnt % 12 >= 6);
	// The crystal needs a start-up span before it reports stable.
	// Outside crystal mode the detector output is meaningless and may read high.
	assign xtal_stable = xt > 30;
	assign pll_level = cnt % 4 >= 2;
	assign pll_locked = cnt > 40;
endmodule

// *** tb/system_clock_control_assertions.sv ***
// Concurrent checks on the ports of the system clock control block.
// Assumes binding to system_clock_control; all checks run on CLK.
`timescale 1ns/100ps
module system_clock_control_assertions #(
	parameter logic [7:0] TRIM_RESET = 8'h80,
	parameter logic [15:0] MCD_TIMEOUT = 16'h0014
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire clkctl_pkg::sfr_req_s SFR_REQ,
	input wire logic [7:0] SFR_RDATA,
	input wire logic PLL_LOCKED,
	input wire logic MCD_ENABLE,
	input wire logic INT_OSC_ENABLE,
	input wire logic [7:0] INT_OSC_TRIM,
	input wire logic [2:0] EXT_OSC_MODE,
	input wire logic [2:0] EXT_FREQ_RANGE,
	input wire logic SYSTEM_CLOCK,
	input wire logic PLL_LOCK_FLAG,
	input wire logic MCD_RESET
);
	logic prev_ff;
	logic [15:0] stall_ff;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// Counts cycles with no system clock change while detection is enabled.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			prev_ff <= 1'b0;
			stall_ff <= 16'h0000;
		end else begin
			prev_ff <= SYSTEM_CLOCK;
			if (!MCD_ENABLE || SYSTEM_CLOCK != prev_ff) begin
				stall_ff <= 16'h0000;
			end else if (stall_ff != 16'hffff) begin
				stall_ff <= stall_ff + 16'h0001;
			end
		end
	end
	sequence rd_of(logic [7:0] a);
		CE && SFR_REQ.re && !SFR_REQ.we && SFR_REQ.addr == a;
	endsequence
	sequence wr_of(logic [7:0] a);
		CE && SFR_REQ.we && SFR_REQ.addr == a;
	endsequence
	trim_reset_a: assert property ($rose(RST_N) |-> INT_OSC_TRIM == TRIM_RESET)
		else $error("trim reset value wrong");
	ctrl_reset_a: assert property ($rose(RST_N) |-> INT_OSC_ENABLE
		&& EXT_OSC_MODE == 3'h0 && EXT_FREQ_RANGE == 3'h0)
		else $error("control reset values wrong");
	trim_write_a: assert property (wr_of(8'h8b) |=> INT_OSC_TRIM == $past(SFR_REQ.wdata))
		else $error("trim write lost");
	trim_read_a: assert property (rd_of(8'h8b) |=> SFR_RDATA == $past(INT_OSC_TRIM))
		else $error("trim read wrong");
	ext_write_a: assert property (wr_of(8'h8c) |=>
		EXT_OSC_MODE == $past(SFR_REQ.wdata[6:4])
		&& EXT_FREQ_RANGE == $past(SFR_REQ.wdata[2:0]))
		else $error("external control write lost");
	ext_rsvd_a: assert property (rd_of(8'h8c) |=> SFR_RDATA[3] == 1'b0)
		else $error("reserved bit read nonzero");
	xtal_flag_a: assert property (rd_of(8'h8c) |=> !SFR_RDATA[7]
		|| $past(EXT_OSC_MODE) >= 3'h6 || $past(EXT_OSC_MODE, 2) >= 3'h6)
		else $error("crystal valid outside crystal mode");
	lock_copy_a: assert property (CE |=> PLL_LOCK_FLAG == $past(PLL_LOCKED))
		else $error("lock flag does not follow lock");
	runt_high_a: assert property ($rose(SYSTEM_CLOCK) |=> SYSTEM_CLOCK)
		else $error("one cycle high pulse on system clock");
	runt_low_a: assert property ($fell(SYSTEM_CLOCK) |=> !SYSTEM_CLOCK)
		else $error("one cycle low pulse on system clock");
	mcd_fire_a: assert property ($rose(MCD_RESET) |->
		stall_ff >= MCD_TIMEOUT - 16'h0003 && stall_ff <= MCD_TIMEOUT + 16'h0002)
		else $error("missing clock reset at wrong time");
	mcd_off_a: assert property (!MCD_ENABLE ##1 !MCD_ENABLE |-> !MCD_RESET)
		else $error("missing clock reset while disabled");
endmodule
bind system_clock_control system_clock_control_assertions #(
	.TRIM_RESET(TRIM_RESET),
	.MCD_TIMEOUT(MCD_TIMEOUT)
) checker_inst (
	.CLK(CLK), .RST_N(RST_N), .CE(CE), .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA),
	.PLL_LOCKED(PLL_LOCKED), .MCD_ENABLE(MCD_ENABLE), .INT_OSC_ENABLE(INT_OSC_ENABLE),
	.INT_OSC_TRIM(INT_OSC_TRIM), .EXT_OSC_MODE(EXT_OSC_MODE), .EXT_FREQ_RANGE(EXT_FREQ_RANGE),
	.SYSTEM_CLOCK(SYSTEM_CLOCK), .PLL_LOCK_FLAG(PLL_LOCK_FLAG), .MCD_RESET(MCD_RESET)
);

// *** tb/tb_top.sv ***
// Self-checking bench for the system clock control block.
// Assumes osc_model as the far side and the bound assertion checker.
`timescale 1ns/100ps
module tb_top;
	localparam logic [7:0] TRIM = 8'h5a;
	logic clk, rst_n, mcd_en, stop, ce;
	logic int_level, int_settled, pin_a, ext_level, xtal_stable, pll_level, pll_locked;
	logic int_en, ext_clk, lock_flag, mcd_rst, sys_clk, clk_out;
	logic [7:0] rdata, trim;
	logic [2:0] mode, freq;
	clkctl_pkg::sfr_req_s req;
	int mismatches = 0;
	int tests_run = 0;
	system_clock_control #(.TRIM_RESET(TRIM), .MCD_TIMEOUT(16'h0014)) system_clock_control_inst (
		.CLK(clk), .RST_N(rst_n), .CE(ce), .SFR_REQ(req), .SFR_RDATA(rdata),
		.INT_OSC_LEVEL(int_level), .INT_OSC_SETTLED(int_settled), .CRYSTAL_PIN_A(pin_a),
		.EXT_OSC_LEVEL(ext_level), .CRYSTAL_STABLE(xtal_stable), .PLL_CLOCK_LEVEL(pll_level),
		.PLL_LOCKED(pll_locked), .MCD_ENABLE(mcd_en), .INT_OSC_ENABLE(int_en),
		.INT_OSC_TRIM(trim), .EXT_OSC_MODE(mode), .EXT_FREQ_RANGE(freq),
		.SYSTEM_CLOCK(sys_clk), .CLOCK_OUT(clk_out), .EXT_PERIPH_CLOCK(ext_clk),
		.PLL_LOCK_FLAG(lock_flag), .MCD_RESET(mcd_rst)
	);
	osc_model osc_model_inst (
		.clk(clk), .int_en(int_en), .ext_mode(mode), .stop(stop), .int_level(int_level),
		.int_settled(int_settled), .pin_a(pin_a), .ext_level(ext_level),
		.xtal_stable(xtal_stable), .pll_level(pll_level), .pll_locked(pll_locked)
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Holds one request for one edge, then leaves an idle cycle before returning.
	task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
		req = '{addr: a, wdata: d, we: w, re: !w};
		@(posedge clk);
		#1;
		req.we = 1'b0;
		req.re = 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		acc(a, 8'h00, 1'b0);
		chk(what, {8'h00, exp}, {8'h00, rdata});
	endtask
	function automatic logic pick(input int w);
		return (w == 0) ? sys_clk : (w == 1) ? clk_out : ext_clk;
	endfunction
	// Measures a steady period between the third and fourth rising edges; 0 if none.
	task automatic per(input int w, output int p);
		int n, t0;
		logic v, pv;
		n = 0;
		t0 = 0;
		p = 0;
		pv = pick(w);
		for (int i = 0; i < 400 && n < 4; i++) begin
			@(posedge clk);
			#1;
			v = pick(w);
			if (v && !pv) begin
				n++;
				if (n == 3) t0 = i;
				if (n == 4) p = i - t0;
			end
			pv = v;
		end
	endtask
	task automatic t_reset;
		int p;
		per(0, p);
		chk("system_clock period", 16'h0040, 16'(p));
		rd(8'h8a, 8'hc0, "int ctrl");
		rd(8'h8b, TRIM, "trim");
		rd(8'h55, 8'h00, "unmapped");
		rd(8'h8c, 8'h00, "ext ctrl");
		rd(8'h97, 8'h00, "source select");
		// A write while the clock enable is low must not land.
		ce = 1'b0;
		acc(8'h8b, 8'h33, 1'b1);
		ce = 1'b1;
		rd(8'h8b, TRIM, "trim frozen");
		acc(8'h8b, 8'ha5, 1'b1);
		chk("trim port", 16'h00a5, {8'h00, trim});
		rd(8'h8b, 8'ha5, "trim written");
		$display("test reset done");
	endtask
	task automatic t_intdiv;
		int p;
		for (int c = 0; c < 4; c++) begin
			acc(8'h8a, 8'h80 | 8'(c), 1'b1);
			per(0, p);
			chk("int div period", 16'h0040 >> c, 16'(p));
		end
		acc(8'h8a, 8'h7f, 1'b1);
		rd(8'h8a, 8'h03, "disabled ctrl");
		$display("test intdiv done");
	endtask
	task automatic t_ext;
		int p;
		int ep[8] = '{0, 0, 10, 20, 24, 24, 12, 24};
		for (int m = 0; m < 8; m++) begin
			acc(8'h8c, 8'h88 | 8'(m << 4) | 8'(m), 1'b1);
			per(2, p);
			chk("ext periph period", 16'(ep[m]), 16'(p));
			chk("freq range port", 16'(m), {13'h0000, freq});
			repeat (40) @(posedge clk);
			#1;
			rd(8'h8c, (m >= 6 ? 8'h80 : 8'h00) | 8'(m << 4) | 8'(m), "ext ctrl");
		end
		$display("test ext done");
	endtask
	task automatic t_switch;
		int p;
		acc(8'h8c, 8'h60, 1'b1);
		repeat (40) @(posedge clk);
		#1;
		rd(8'h8c, 8'he0, "crystal valid");
		acc(8'h97, 8'h01, 1'b1);
		per(0, p);
		chk("ext system_clock", 16'h000c, 16'(p));
		chk("lock flag", 16'h0001, {15'h0000, lock_flag});
		acc(8'h97, 8'h02, 1'b1);
		per(0, p);
		chk("pll system_clock", 16'h0004, 16'(p));
		acc(8'h97, 8'h03, 1'b1);
		per(0, p);
		chk("reserved code", 16'h0004, 16'(p));
		acc(8'h8a, 8'h83, 1'b1);
		acc(8'h97, 8'h00, 1'b1);
		per(0, p);
		chk("int system_clock", 16'h0008, 16'(p));
		$display("test switch done");
	endtask
	task automatic t_outdiv;
		int p;
		for (int k = 0; k < 4; k++) begin
			acc(8'h97, 8'hcc | 8'(k << 4), 1'b1);
			per(1, p);
			chk("clock out period", 16'h0008 << k, 16'(p));
			rd(8'h97, 8'(k << 4), "source select");
		end
		$display("test outdiv done");
	endtask
	task automatic t_mcd;
		int n;
		mcd_en = 1'b1;
		repeat (40) @(posedge clk);
		#1;
		chk("mcd idle", 16'h0000, {15'h0000, mcd_rst});
		stop = 1'b1;
		n = 0;
		while (mcd_rst !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("mcd delay", 16'h0001, {15'h0000, n >= 14 && n <= 24});
		stop = 1'b0;
		repeat (10) @(posedge clk);
		#1;
		chk("mcd release", 16'h0000, {15'h0000, mcd_rst});
		mcd_en = 1'b0;
		$display("test mcd done");
	endtask
	// A reset in mid-run, during a move to the PLL, must fall back to the internal source.
	task automatic t_rerst;
		int p;
		acc(8'h97, 8'h02, 1'b1);
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		rd(8'h97, 8'h00, "source after reset");
		rd(8'h8b, TRIM, "trim after reset");
		per(0, p);
		chk("system_clock after reset", 16'h0040, 16'(p));
		$display("test rerst done");
	endtask
	initial begin
		#200000;
		mismatches++;
		give_verdict();
	end
	initial begin
		rst_n = 1'b0;
		mcd_en = 1'b0;
		stop = 1'b0;
		ce = 1'b1;
		req = '0;
		repeat (4) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_reset();
		t_intdiv();
		t_ext();
		t_switch();
		t_outdiv();
		t_mcd();
		t_rerst();
		give_verdict();
	end
endmodule
